// file: rtl/cpc_pkg.sv
// Package with register map, field positions and shared types.
package cpc_pkg;
  localparam int cpc_addr_width = 32;
  localparam logic [31:0] cpc_off_cb3 = 32'h4f00_00a4;
  localparam logic [31:0] cpc_off_cb4 = 32'h4f00_00a8;
  localparam logic [31:0] cpc_off_cr1 = 32'h4f00_00ac;
  localparam logic [31:0] cpc_off_cr2 = 32'h4f00_00b0;
  localparam logic [31:0] cpc_off_cr3 = 32'h4f00_00b4;
  localparam logic [31:0] cpc_off_cr4 = 32'h4f00_00b8;
  localparam logic [31:0] cpc_off_ctrl = 32'h4f00_00bc;
  // Readable status, interrupt status and mask words.
  localparam logic [31:0] cpc_off_state = 32'h4f00_0000;
  localparam logic [31:0] cpc_off_irq_status = 32'h4f00_00c0;
  localparam logic [31:0] cpc_off_irq_mask = 32'h4f00_00c4;
  localparam logic [31:0] cpc_rst_frame1 = 32'hc073_f000;
  localparam logic [31:0] cpc_rst_frame2 = 32'hc07e_ec80;
  localparam logic [31:0] cpc_rst_frame3 = 32'hc089_e900;
  localparam logic [31:0] cpc_rst_frame4 = 32'hc094_e580;
  localparam logic [31:0] cpc_rst_ctrl = 32'h0000_0000;
  localparam int cpc_bit_soft_reset = 30;
  localparam int cpc_bit_same_image = 29;
  localparam int cpc_bit_frame_hi = 27;
  localparam int cpc_bit_frame_lo = 26;
  localparam int cpc_bit_burst_src = 20;
  localparam int cpc_bit_cam_reset = 19;
  localparam int cpc_bit_capture = 18;
  localparam int cpc_bit_irq_clear = 17;
  localparam int cpc_bit_pattern_hi = 16;
  localparam int cpc_bit_pattern_lo = 14;
  localparam int cpc_bit_swap = 13;
  localparam int cpc_bit_order = 12;
  localparam int cpc_bit_offset_bin = 11;
  // Interrupt event bits.
  localparam int cpc_irq_bit_frame = 0;
  localparam int cpc_irq_bit_vsync_fall = 1;
  localparam int cpc_irq_width = 2;
  localparam int cpc_sync_stages = 3;

  typedef enum logic [2:0] {
    cpc_pat_bypass,
    cpc_pat_color_bar,
    cpc_pat_square_box,
    cpc_pat_solid_line,
    cpc_pat_check,
    cpc_pat_h_increasing,
    cpc_pat_dc,
    cpc_pat_reserved
  } cpc_pattern_type;

  // Decoded configuration handed to the capture datapath.
  typedef struct packed {
    logic interface_soft_reset;
    logic dual_port_same_image;
    logic burst_length_source;
    logic external_camera_reset;
    logic interrupt_clear;
    cpc_pattern_type pattern_select;
    logic luma_chroma_swap;
    logic luma_chroma_order;
    logic chroma_offset_binary;
  } cpc_config_type;

  // B-port chroma start addresses: Cb for frames three and four, Cr for frames one to four.
  typedef struct packed {
    logic [31:0] cb3;
    logic [31:0] cb4;
    logic [31:0] cr1;
    logic [31:0] cr2;
    logic [31:0] cr3;
    logic [31:0] cr4;
  } cpc_addr_set_type;
endpackage : cpc_pkg

// file: rtl/cpc_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module cpc_sync
  import cpc_pkg::*;
#(
  parameter int stages = cpc_sync_stages
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);
  logic [stages-1:0] chain;

  // The agreement filter reads stages one and two, so only three make sense.
  if (stages != 3)
  begin : g_bad_stages
    $error("cpc_sync supports exactly three stages");
  end

  // Shift the pin through the chain; stage zero feeds only stage one.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      chain <= '0;
    else
      chain <= {chain[stages-2:0], async_in};
  end

  // Accept a change only once the last two stages agree.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sync_out <= 1'b0;
    else if (chain[1] == chain[2])
      sync_out <= chain[2];
  end
endmodule : cpc_sync

// file: rtl/cpc_regs.sv
// Camera port control register bank with status and interrupt logic.
//
// How it works
// - Write-only Cb frame three start, reset value.
// - Write-only Cb frame four start, reset value.
// - Write-only Cr frames one, two starts.
// - Write-only Cr frames three, four starts.
// - Write-only control word, all zero at reset.
// - Bit 30 holds interface in soft reset.
// - Bit 29 makes both ports show scaled image.
// - Bit 20 picks software or self burst length.
// - Bit 19 resets the external camera.
// - Writing bit 18 gives one-cycle capture pulse.
// - Writing bit 17 clears camera interrupt.
// - Bits 16 to 14 select video pattern.
// - Bit 13 selects UYVY or YUYV order.
// - Bit 11 selects offset binary chroma.
// - Capture state stays high until vsync falls.
// - Two-bit B-port frame index readable.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module cpc_regs
  import cpc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic vsync_pin,
  input wire logic b_frame_done,
  output cpc_config_type config_out,
  output cpc_addr_set_type b_addr,
  output logic a_capture_pulse,
  output logic a_port_capture_state,
  output logic [1:0] b_port_frame_index,
  output logic external_camera_reset,
  output logic interface_soft_reset,
  output logic irq
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [cpc_irq_width-1:0] irq_status;
  logic [cpc_irq_width-1:0] irq_mask;
  logic [cpc_irq_width-1:0] irq_events;
  logic vsync_sync;
  logic vsync_prev;
  logic vsync_fall;
  logic wr_ctrl;
  logic soft_rst_now;

  // Only the documented fields survive a write; others read back as zero.
  localparam logic [31:0] ctrl_keep_mask = 32'h601f_f800;

  // The vsync pin is asynchronous to the bus clock.
  cpc_sync #(
    .stages(cpc_sync_stages)
  ) u_vsync_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(vsync_pin),
    .sync_out(vsync_sync)
  );

  assign wr_ctrl = reg_write && (reg_addr == cpc_off_ctrl);
  assign next_ctrl = reg_wdata & ctrl_keep_mask;
  assign soft_rst_now = ctrl[cpc_bit_soft_reset];

  // Chroma start addresses, each a plain write-only word.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      b_addr.cb3 <= cpc_rst_frame3;
      b_addr.cb4 <= cpc_rst_frame4;
      b_addr.cr1 <= cpc_rst_frame1;
      b_addr.cr2 <= cpc_rst_frame2;
      b_addr.cr3 <= cpc_rst_frame3;
      b_addr.cr4 <= cpc_rst_frame4;
    end
    else if (reg_write)
    begin
      if (reg_addr == cpc_off_cb3)
        b_addr.cb3 <= reg_wdata;
      if (reg_addr == cpc_off_cb4)
        b_addr.cb4 <= reg_wdata;
      if (reg_addr == cpc_off_cr1)
        b_addr.cr1 <= reg_wdata;
      if (reg_addr == cpc_off_cr2)
        b_addr.cr2 <= reg_wdata;
      if (reg_addr == cpc_off_cr3)
        b_addr.cr3 <= reg_wdata;
      if (reg_addr == cpc_off_cr4)
        b_addr.cr4 <= reg_wdata;
    end
  end

  // Control word; capture and interrupt-clear bits self-clear next cycle.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl <= cpc_rst_ctrl;
    else if (wr_ctrl)
      ctrl <= next_ctrl;
    else
    begin
      ctrl[cpc_bit_capture] <= 1'b0;
      ctrl[cpc_bit_irq_clear] <= 1'b0;
    end
  end

  // Decoded fields for the datapath.
  always_comb
  begin
    config_out.interface_soft_reset = ctrl[cpc_bit_soft_reset];
    config_out.dual_port_same_image = ctrl[cpc_bit_same_image];
    config_out.burst_length_source = ctrl[cpc_bit_burst_src];
    config_out.external_camera_reset = ctrl[cpc_bit_cam_reset];
    config_out.interrupt_clear = ctrl[cpc_bit_irq_clear];
    config_out.pattern_select = cpc_pattern_type'(
      ctrl[cpc_bit_pattern_hi:cpc_bit_pattern_lo]);
    config_out.luma_chroma_swap = ctrl[cpc_bit_swap];
    config_out.luma_chroma_order = ctrl[cpc_bit_order];
    config_out.chroma_offset_binary = ctrl[cpc_bit_offset_bin];
  end

  assign interface_soft_reset = ctrl[cpc_bit_soft_reset];
  assign external_camera_reset = ctrl[cpc_bit_cam_reset];
  assign a_capture_pulse = ctrl[cpc_bit_capture];

  // Edge detect works on the filtered copy, never the raw first stage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      vsync_prev <= 1'b0;
    else
      vsync_prev <= vsync_sync;
  end

  assign vsync_fall = vsync_prev && !vsync_sync;

  // Capture state: set by the pulse, held until vsync falls.
  // A pulse landing on the falling edge wins, so the request is not lost.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      a_port_capture_state <= 1'b0;
    else if (soft_rst_now)
      a_port_capture_state <= 1'b0;
    else if (a_capture_pulse)
      a_port_capture_state <= 1'b1;
    else if (vsync_fall)
      a_port_capture_state <= 1'b0;
  end

  // B-port frame index advances per completed frame, wraps after four.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      b_port_frame_index <= 2'h0;
    else if (soft_rst_now)
      b_port_frame_index <= 2'h0;
    else if (b_frame_done)
      b_port_frame_index <= b_port_frame_index + 2'h1;
  end

  // Interrupt events: frame completion and vsync falling edge.
  always_comb
  begin
    irq_events = '0;
    irq_events[cpc_irq_bit_frame] = b_frame_done;
    irq_events[cpc_irq_bit_vsync_fall] = vsync_fall;
  end

  // Sticky status, cleared by the interrupt-clear bit or by writing ones.
  // A new event in the clearing cycle is kept, so the set wins.
  // The global clear goes first so a status write beside it loses nothing.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= '0;
    else if (ctrl[cpc_bit_irq_clear])
      irq_status <= irq_events;
    else if (reg_write && reg_addr == cpc_off_irq_status)
      irq_status <= (irq_status & ~reg_wdata[cpc_irq_width-1:0])
        | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  // Interrupt mask; a set bit lets that status bit reach the output.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_mask <= '0;
    else if (reg_write && reg_addr == cpc_off_irq_mask)
      irq_mask <= reg_wdata[cpc_irq_width-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // Read data one cycle after the strobe; write-only words read as zero.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      reg_rdata <= '0;
      if (reg_addr == cpc_off_state)
      begin
        reg_rdata[cpc_bit_frame_hi:cpc_bit_frame_lo] <=
          b_port_frame_index;
        reg_rdata[cpc_bit_cam_reset] <= ctrl[cpc_bit_cam_reset];
        reg_rdata[cpc_bit_capture] <= a_port_capture_state;
        reg_rdata[cpc_bit_irq_clear] <= ctrl[cpc_bit_irq_clear];
        reg_rdata[cpc_bit_pattern_hi:cpc_bit_pattern_lo] <=
          ctrl[cpc_bit_pattern_hi:cpc_bit_pattern_lo];
      end
      else if (reg_addr == cpc_off_irq_status)
        reg_rdata[cpc_irq_width-1:0] <= irq_status;
      else if (reg_addr == cpc_off_irq_mask)
        reg_rdata[cpc_irq_width-1:0] <= irq_mask;
    end
    else
      reg_rdata <= '0;
  end
endmodule : cpc_regs

// file: verification/cpc_regs_properties.sv
// Concurrent checks on the camera port control register bank ports.
`timescale 1ns/1ps
module cpc_regs_properties
  import cpc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire cpc_config_type config_out,
  input wire cpc_addr_set_type b_addr,
  input wire logic a_capture_pulse,
  input wire logic a_port_capture_state,
  input wire logic external_camera_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A control word write, and a capture request without soft reset.
  sequence s_ctrl;
    reg_write && reg_addr == cpc_off_ctrl;
  endsequence
  sequence s_cap;
    s_ctrl ##0 reg_wdata[18] && !reg_wdata[30];
  endsequence
  a_capture_pulse_state: assert property (
    s_cap |=> a_capture_pulse ##1 a_port_capture_state)
    else $error("capture pulse or state missing");
  a_pulse_has_cause: assert property (
    a_capture_pulse |->
      $past(reg_write && reg_addr == cpc_off_ctrl && reg_wdata[18]))
    else $error("capture pulse without a write");
  a_cam_reset_follow: assert property (
    s_ctrl |=> external_camera_reset == $past(reg_wdata[19]))
    else $error("camera reset not from bit 19");
  a_soft_reset_field: assert property (
    s_ctrl |=> config_out.interface_soft_reset == $past(reg_wdata[30]))
    else $error("soft reset not from bit 30");
  a_pattern_field: assert property (
    s_ctrl |=> config_out.pattern_select == $past(reg_wdata[16:14]))
    else $error("pattern not from bits 16 to 14");
  a_irq_clear_pulse: assert property (
    s_ctrl ##0 reg_wdata[17] |=> config_out.interrupt_clear)
    else $error("interrupt clear missing");
  a_cb3_write: assert property (
    reg_write && reg_addr == cpc_off_cb3 |=> b_addr.cb3 == $past(reg_wdata))
    else $error("cb3 start not written");
  a_ctrl_reads_zero: assert property (
    reg_read && reg_addr == cpc_off_ctrl |=> reg_rdata == 32'h0000_0000)
    else $error("write-only word read nonzero");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule : cpc_regs_properties

bind cpc_regs cpc_regs_properties u_props (.clk, .rstn, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .config_out, .b_addr,
  .a_capture_pulse, .a_port_capture_state, .external_camera_reset);

// file: verification/cpc_cam_model.sv
// Behavioural model of the external camera's vertical sync output.
`timescale 1ns/1ps
module cpc_cam_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cam_reset,
  input wire logic frame_req,
  output logic vsync_pin
);
  logic [3:0] left;
  // One short frame per request; a camera held in reset stays silent.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      left <= 4'h0;
      vsync_pin <= 1'b0;
    end
    else if (cam_reset)
    begin
      left <= 4'h0;
      vsync_pin <= 1'b0;
    end
    else if (frame_req && left == 4'h0)
    begin
      left <= 4'h6;
      vsync_pin <= 1'b1;
    end
    else if (left != 4'h0)
    begin
      left <= left - 4'h1;
      vsync_pin <= (left != 4'h1);
    end
  end
endmodule : cpc_cam_model

// file: verification/tb_top.sv
// Self-checking bench for the camera port control register bank.
`timescale 1ns/1ps
module tb_top
  import cpc_pkg::*;
;
  logic clk, rstn, reg_write, reg_read, b_frame_done, frame_req, vsync_pin;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, v;
  logic a_capture_pulse, a_port_capture_state, irq;
  logic external_camera_reset, interface_soft_reset;
  logic [1:0] b_port_frame_index;
  cpc_config_type config_out;
  cpc_addr_set_type b_addr;
  int err_total, checks_done;
  cpc_regs dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .vsync_pin, .b_frame_done, .config_out, .b_addr,
    .a_capture_pulse, .a_port_capture_state, .b_port_frame_index,
    .external_camera_reset, .interface_soft_reset, .irq);
  cpc_cam_model u_cam (.clk, .rstn, .cam_reset(external_camera_reset),
    .frame_req, .vsync_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Drives one bus cycle just after a rising edge.
  task automatic bus(input logic w, r, input logic [31:0] a, d);
    @(posedge clk);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    bus(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    #1 v = reg_rdata;
  endtask : rd
  task automatic done_pulse;
    @(posedge clk);
    b_frame_done <= 1'b1;
    @(posedge clk);
    b_frame_done <= 1'b0;
    #1;
  endtask : done_pulse
  task automatic t_reset;
    chk(b_addr.cb3, cpc_rst_frame3);
    chk(b_addr.cb4, cpc_rst_frame4);
    chk(b_addr.cr1, cpc_rst_frame1);
    chk(b_addr.cr2, cpc_rst_frame2);
    chk(b_addr.cr3, cpc_rst_frame3);
    chk(b_addr.cr4, cpc_rst_frame4);
    chk(32'(config_out), cpc_rst_ctrl);
  endtask : t_reset
  // Back-to-back writes to all six start words, then write-only reads.
  task automatic t_addr;
    for (int i = 0; i < 6; i++)
      bus(1'b1, 1'b0, cpc_off_cb3 + 32'(4 * i), 32'h1000_0000 + 32'(i));
    bus(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    #1;
    chk(b_addr.cb3, 32'h1000_0000);
    chk(b_addr.cb4, 32'h1000_0001);
    chk(b_addr.cr1, 32'h1000_0002);
    chk(b_addr.cr2, 32'h1000_0003);
    chk(b_addr.cr3, 32'h1000_0004);
    chk(b_addr.cr4, 32'h1000_0005);
    rd(cpc_off_cb4);
    chk(v, 32'h0000_0000);
    rd(32'h4f00_0098);
    chk(v, 32'h0000_0000);
  endtask : t_addr
  // Every pattern code, flags toggled, undefined bits always set.
  // Software keeps the order bit at zero, as it is advised to.
  task automatic t_ctrl;
    logic f;
    logic [31:0] w, e;
    for (int p = 0; p < 8; p++)
    begin
      f = p[0];
      w = {1'b1, f, f, 8'hff, f, f, 2'b00, p[2:0], f, 1'b0, f, 11'h7ff};
      e = 32'({f, f, f, f, 1'b0, p[2:0], f, 1'b0, f});
      wr(cpc_off_ctrl, w);
      chk(32'(config_out), e);
      chk(32'(interface_soft_reset), 32'(f));
      chk(32'(external_camera_reset), 32'(f));
    end
    rd(cpc_off_ctrl);
    chk(v, 32'h0000_0000);
    rd(cpc_off_state);
    chk(v, 32'h0009_c000);
  endtask : t_ctrl
  // Capture request, held until the synchronised sync edge falls.
  task automatic t_capture;
    int n;
    wr(cpc_off_ctrl, 32'h0004_0000);
    chk(32'(a_capture_pulse), 32'h0000_0001);
    @(posedge clk);
    frame_req <= 1'b1;
    #1 chk(32'(a_capture_pulse), 32'h0000_0000);
    chk(32'(a_port_capture_state), 32'h0000_0001);
    @(posedge clk);
    frame_req <= 1'b0;
    #1 n = 0;
    while (vsync_pin !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'({vsync_pin, a_port_capture_state}), 32'h0000_0001);
    repeat (5) @(posedge clk);
    #1 chk(32'(a_port_capture_state), 32'h0000_0000);
  endtask : t_capture
  // Frame events: index wrap, masking, clears and soft reset.
  task automatic t_irq;
    rd(cpc_off_irq_status);
    chk(v, 32'h0000_0002);
    wr(cpc_off_irq_mask, 32'h0000_0001);
    done_pulse();
    chk(32'({b_port_frame_index, irq}), 32'h0000_0003);
    wr(cpc_off_irq_status, 32'h0000_0001);
    wr(cpc_off_irq_mask, 32'h0000_0000);
    done_pulse();
    chk(32'(irq), 32'h0000_0000);
    wr(cpc_off_irq_mask, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(cpc_off_ctrl, 32'h0002_0000);
    @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0000);
    done_pulse();
    done_pulse();
    rd(cpc_off_state);
    chk(32'(v[27:26]), 32'h0000_0000);
    done_pulse();
    wr(cpc_off_ctrl, 32'h4000_0000);
    @(posedge clk);
    #1 chk(32'(b_port_frame_index), 32'h0000_0000);
    wr(cpc_off_ctrl, 32'h0000_0000);
  endtask : t_irq
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Free-running 250 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Reset for eight cycles, then each scenario in turn.
  initial
  begin
    rstn = 1'b0;
    {reg_write, reg_read, b_frame_done, frame_req} = 4'h0;
    reg_addr = 32'h0000_0000;
    reg_wdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    #1 t_reset();
    t_addr();
    t_ctrl();
    t_capture();
    t_irq();
    complete_run();
  end
  // The whole run needs well under a thousand cycles.
  initial
  begin
    #20000 err_total++;
    complete_run();
  end
endmodule : tb_top
